// ==== common/fpu_flag_pkg.sv ====
// Constants, encodings and types shared by the flag and rounding stage
package fpu_flag_pkg;
	// Rounding-mode field encodings
	localparam logic [1:0] RM_NEAREST = 2'h0;
	localparam logic [1:0] RM_ZERO    = 2'h1;
	// Precision-select encodings
	localparam logic PREC_SINGLE = 1'h0;
	localparam logic PREC_DOUBLE = 1'h1;

	// Widths of the packed formats
	localparam int EXP_W    = 11;
	localparam int FRAC_W   = 52;
	localparam int SEXP_W   = 8;
	localparam int SFRAC_W  = 23;
	localparam int BODY_W   = EXP_W + FRAC_W;
	// Single fraction sits in the top bits of the shared fraction bus
	localparam int SGL_SHIFT = FRAC_W - SFRAC_W;
	localparam int SGL_GUARD = SGL_SHIFT - 1;

	// Exponent limits
	localparam logic [EXP_W-1:0] DEXP_ONES = 11'h7ff;
	localparam logic [EXP_W-1:0] SEXP_ONES = 11'h0ff;
	localparam logic [EXP_W-1:0] EXP_ZERO  = 11'h000;
	// Largest normal single value, written on overflow when rounding toward zero
	localparam logic [31:0] SGL_MAX_NORMAL = 32'h7f7fffff;
	localparam logic [63:0] DBL_MAX_NORMAL = 64'h7fefffffffffffff;
	localparam logic [31:0] SGL_INF        = 32'h7f800000;
	localparam logic [63:0] DBL_INF        = 64'h7ff0000000000000;
	localparam int SGL_SIGN = 31;
	localparam int DBL_SIGN = 63;

	// Double add/subtract window with missed inexact
	localparam logic [EXP_W-1:0] QUIRK_DIFF_LO = 11'h02b;
	localparam logic [EXP_W-1:0] QUIRK_DIFF_HI = 11'h032;
	localparam int QUIRK_ONE_HI  = 31;
	localparam int QUIRK_ONE_LO  = 24;
	localparam int QUIRK_ZLO_HI  = 23;
	localparam int QUIRK_ZLO_LO  = 0;
	localparam int QUIRK_ZHI_HI  = 40;
	localparam int QUIRK_ZHI_LO  = 32;

	// Cause bit positions; flag and enable use the low five
	localparam int EXC_W = 5;
	localparam int CAUSE_W = 6;
	localparam int BIT_I = 0;
	localparam int BIT_U = 1;
	localparam int BIT_O = 2;
	localparam int BIT_Z = 3;
	localparam int BIT_V = 4;
	localparam int BIT_E = 5;

	// Least count of infinite operands for the sign fault
	localparam logic [2:0] INF_MIN_COUNT = 3'h2;

	typedef enum logic [2:0] {
		fp_add_op,
		fp_subtract_op,
		fp_multiply_op,
		fp_divide_op,
		fp_multiply_accumulate_op,
		inner_product_op,
		matrix_vector_transform_op
	} op_kind_t;
endpackage

// ==== src/fpu_rounder.sv ====
// Rounding of an unrounded result to single or double precision
`timescale 1ns/1ps
module fpu_rounder
	import fpu_flag_pkg::*;
(
	input  wire logic              prec,
	input  wire logic [1:0]        rm,
	input  wire logic              sign,
	input  wire logic [EXP_W-1:0]  exp,
	input  wire logic [FRAC_W-1:0] frac,
	input  wire logic              guard_in,
	input  wire logic              sticky_in,
	input  wire logic              flip,
	output logic      [63:0]       result,
	output logic                   inexact,
	output logic                   tiny,
	output logic                   to_normal,
	output logic                   overflow
);
	// Exponent field of a packed body at the selected precision
	function automatic logic [EXP_W-1:0] exp_of(input logic p, input logic [BODY_W-1:0] b);
		if (p == PREC_DOUBLE) begin
			return b[BODY_W-1:FRAC_W];
		end
		return {3'h0, b[SEXP_W+SFRAC_W-1:SFRAC_W]};
	endfunction

	logic [BODY_W-1:0] base;
	logic [BODY_W-1:0] sum;
	logic              guard;
	logic              sticky;
	logic              lsb;
	logic              inc_ok;
	logic              inc;
	logic [EXP_W-1:0]  ones;

	// Align the body, then find guard, sticky and the kept LSB
	always_comb begin
		if (prec == PREC_DOUBLE) begin
			base   = {exp, frac};
			guard  = guard_in;
			sticky = sticky_in;
			lsb    = frac[0];
			ones   = DEXP_ONES;
		end else begin
			base   = {{(BODY_W-SEXP_W-SFRAC_W){1'b0}}, exp[SEXP_W-1:0], frac[FRAC_W-1:SGL_SHIFT]};
			guard  = frac[SGL_GUARD];
			sticky = (|frac[SGL_GUARD-1:0]) | guard_in | sticky_in;
			lsb    = frac[SGL_SHIFT];
			ones   = SEXP_ONES;
		end
		inexact = guard | sticky;
		inc_ok  = (rm == RM_NEAREST) & guard & (sticky | lsb);
		inc     = (flip & inexact) ? ~inc_ok : inc_ok;
		sum     = base + {{(BODY_W-1){1'b0}}, inc};
		tiny    = (exp_of(prec, base) == EXP_ZERO);
		to_normal = tiny & (exp_of(prec, sum) != EXP_ZERO);
		overflow  = (exp_of(prec, sum) == ones);
	end

	// Pack the rounded value; overflow gives infinity or the largest normal
	always_comb begin
		if (prec == PREC_DOUBLE) begin
			if (overflow) begin
				result = (rm == RM_ZERO) ? DBL_MAX_NORMAL : DBL_INF;
			end else begin
				result = {1'b0, sum};
			end
			result[DBL_SIGN] = sign;
		end else begin
			if (overflow) begin
				result = {32'h0, (rm == RM_ZERO) ? SGL_MAX_NORMAL : SGL_INF};
			end else begin
				result = {32'h0, sum[31:0]};
			end
			result[SGL_SIGN] = sign;
		end
	end
endmodule

// ==== src/fpu_flag_unit.sv ====
// Completion stage of the FPU: rounding, exception cause, sticky flags and trap
`timescale 1ns/1ps
// Functional notes
// - Round-nearest tiny-to-normal: underflow flag stays clear
// - Still writes the correctly rounded normal value
// - Sets inexact instead of underflow there
// - Single window between largest denormal, smallest normal
// - Double window likewise, both signs
// - Rounding field 00 nearest, 01 toward zero
// - Precision bit 0 single, 1 double
// - Trap for sources whose enable is set; error source always traps
// - Vector ops may flag overflow on zero result
// - Vector ops sign wrong with same-sign infinities
// - Double add/sub, exponent gap 43-50, inexact missed
// - Needs smaller mantissa pattern on bits 40-0
// - Such cases round to the other neighbour
// - Error up to 1/256 LSB extra, both modes
// - Cause follows event; flag sticky, set only
// - Inner product always sets inexact cause and flag
module fpu_flag_unit
	import fpu_flag_pkg::*;
(
	// Clock and reset
	input  wire logic              CLOCK,
	input  wire logic              RSTN,
	// Mode, precision and trap enable fields
	input  wire logic [1:0]        ROUNDING_MODE_FIELD,
	input  wire logic              PRECISION_SELECT_BIT,
	input  wire logic [EXC_W-1:0]  EXC_ENABLE,
	// Software write of the sticky flags
	input  wire logic              FLAG_LOAD,
	input  wire logic [EXC_W-1:0]  FLAG_LOAD_DATA,
	// Completing op and its unrounded result
	input  wire logic              OP_VALID,
	input  wire op_kind_t          OP_KIND,
	input  wire logic              RAW_SIGN,
	input  wire logic [EXP_W-1:0]  RAW_EXP,
	input  wire logic [FRAC_W-1:0] RAW_FRAC,
	input  wire logic              RAW_GUARD,
	input  wire logic              RAW_STICKY,
	// Exception events from the datapath
	input  wire logic              SRC_ERROR,
	input  wire logic              SRC_INVALID,
	input  wire logic              SRC_DIVZERO,
	input  wire logic              SRC_OVERFLOW,
	// Vector op error bound and infinity status
	input  wire logic              ERR_BOUND_OVF,
	input  wire logic [2:0]        INF_OPERAND_COUNT,
	input  wire logic              INF_SAME_SIGN,
	// Add/subtract operand exponents and smaller mantissa
	input  wire logic [EXP_W-1:0]  OPN_EXP,
	input  wire logic [EXP_W-1:0]  OPM_EXP,
	input  wire logic [FRAC_W-1:0] SMALL_MANT,
	// Completion strobes, destination write and status
	output logic                   DONE,
	output logic                   DEST_WE,
	output logic      [63:0]       DEST_DATA,
	output logic      [CAUSE_W-1:0] CAUSE,
	output logic      [EXC_W-1:0]  FLAGS,
	output logic                   TRAP
);
	// Registered completion state; each output is one field
	typedef struct packed {
		logic               done;
		logic               dest_we;
		logic [63:0]        dest;
		logic [CAUSE_W-1:0] cause;
		logic [EXC_W-1:0]   flags;
		logic               trap;
	} state_t;

	state_t state_r;
	state_t state_nxt;

	////////////////////////////////////////////////////////////////////////////
	// Operation classification

	// Absolute difference of two exponents
	function automatic logic [EXP_W-1:0] exp_gap(input logic [EXP_W-1:0] a,
		input logic [EXP_W-1:0] b);
		if (a > b) begin
			return a - b;
		end
		return b - a;
	endfunction

	logic             is_double;
	logic             is_vector;
	logic             is_addsub;
	logic [EXP_W-1:0] gap;
	logic             gap_hit;
	logic             mant_one;
	logic             mant_zero_lo;
	logic             mant_zero_hi;
	logic             quirk;
	logic             inf_fault;
	logic             sign_eff;

	// Decode precision and op kind
	always_comb begin
		is_double = (PRECISION_SELECT_BIT == PREC_DOUBLE);
		is_vector = (OP_KIND == inner_product_op) || (OP_KIND == matrix_vector_transform_op);
		is_addsub = (OP_KIND == fp_add_op) || (OP_KIND == fp_subtract_op);
	end

	// Add/subtract fault window: exponent gap and smaller mantissa pattern
	always_comb begin
		gap          = exp_gap(OPN_EXP, OPM_EXP);
		gap_hit      = (gap >= QUIRK_DIFF_LO) && (gap <= QUIRK_DIFF_HI);
		mant_one     = |SMALL_MANT[QUIRK_ONE_HI:QUIRK_ONE_LO];
		mant_zero_lo = (SMALL_MANT[QUIRK_ZLO_HI:QUIRK_ZLO_LO] == '0);
		mant_zero_hi = (SMALL_MANT[QUIRK_ZHI_HI:QUIRK_ZHI_LO] == '0);
		// Only double-precision add and subtract show the fault
		quirk        = is_double && is_addsub && gap_hit
			&& mant_one && mant_zero_lo && mant_zero_hi;
	end

	// Infinite partial products of one sign flip the result sign
	always_comb begin
		inf_fault = is_vector && INF_SAME_SIGN && (INF_OPERAND_COUNT >= INF_MIN_COUNT);
		sign_eff  = RAW_SIGN ^ inf_fault;
	end

	////////////////////////////////////////////////////////////////////////////
	// Rounding

	logic [63:0] rnd_result;
	logic        rnd_inexact;
	logic        rnd_tiny;
	logic        rnd_to_normal;
	logic        rnd_overflow;

	fpu_rounder u_rounder (
		.prec      (PRECISION_SELECT_BIT),
		.rm        (ROUNDING_MODE_FIELD),
		.sign      (sign_eff),
		.exp       (RAW_EXP),
		.frac      (RAW_FRAC),
		.guard_in  (RAW_GUARD),
		.sticky_in (RAW_STICKY),
		.flip      (quirk),
		.result    (rnd_result),
		.inexact   (rnd_inexact),
		.tiny      (rnd_tiny),
		.to_normal (rnd_to_normal),
		.overflow  (rnd_overflow)
	);

	////////////////////////////////////////////////////////////////////////////
	// Cause, flag and trap update

	logic [CAUSE_W-1:0] cause_new;
	logic               suppress_u;
	logic               trap_new;
	logic [EXC_W-1:0]   flags_base;

	// Tiny result lifted to normal in nearest mode hides underflow
	always_comb begin
		suppress_u = (ROUNDING_MODE_FIELD == RM_NEAREST) && rnd_to_normal;
	end

	// Exception cause of the completing op
	always_comb begin
		cause_new = '0;
		// Datapath events pass straight through
		cause_new[BIT_E] = SRC_ERROR;
		cause_new[BIT_V] = SRC_INVALID;
		cause_new[BIT_Z] = SRC_DIVZERO;
		// Overflow from the datapath, from rounding or from a vector error bound
		cause_new[BIT_O] = SRC_OVERFLOW || rnd_overflow || (is_vector && ERR_BOUND_OVF);
		// Underflow needs a tiny inexact result not lifted to normal in nearest mode
		cause_new[BIT_U] = rnd_tiny && rnd_inexact && !suppress_u;
		// Inexact from rounding loss unless the add/sub fault masks it; forced cases on top
		cause_new[BIT_I] = (rnd_inexact && !quirk) || suppress_u || is_vector
			|| cause_new[BIT_O];
	end

	// The error source always traps; the others only when enabled
	always_comb begin
		trap_new = cause_new[BIT_E] || (|(cause_new[EXC_W-1:0] & EXC_ENABLE));
	end

	// Software load first, hardware set wins over it
	always_comb begin
		flags_base = FLAG_LOAD ? FLAG_LOAD_DATA : state_r.flags;
	end

	// Build next state at completion
	always_comb begin
		state_nxt         = state_r;
		state_nxt.flags   = flags_base;
		state_nxt.done    = OP_VALID;
		state_nxt.dest_we = 1'b0;
		state_nxt.trap    = 1'b0;
		if (OP_VALID) begin
			state_nxt.cause = cause_new;
			state_nxt.flags = flags_base | cause_new[EXC_W-1:0];
			state_nxt.trap  = trap_new;
			// A trapping op drops the destination write strobe; DEST_DATA still takes the result
			state_nxt.dest_we = !trap_new;
			state_nxt.dest    = rnd_result;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers and outputs

	// State register
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Outputs straight from the state register
	assign DONE      = state_r.done;
	assign DEST_WE   = state_r.dest_we;
	assign TRAP      = state_r.trap;

	// Result and status hold until the next op or load
	assign DEST_DATA = state_r.dest;
	assign CAUSE     = state_r.cause;
	assign FLAGS     = state_r.flags;
endmodule

// ==== verif/fpu_flag_unit_asserts.sv ====
// Concurrent checks on the FPU completion stage ports
`timescale 1ns/1ps
module fpu_flag_unit_asserts
	import fpu_flag_pkg::*;
(
	input wire logic               CLOCK,
	input wire logic               RSTN,
	input wire logic [EXC_W-1:0]   EXC_ENABLE,
	input wire logic               FLAG_LOAD,
	input wire logic               OP_VALID,
	input wire op_kind_t           OP_KIND,
	input wire logic               ERR_BOUND_OVF,
	input wire logic               DONE,
	input wire logic               DEST_WE,
	input wire logic [CAUSE_W-1:0] CAUSE,
	input wire logic [EXC_W-1:0]   FLAGS,
	input wire logic               TRAP
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RSTN);
	////////////////////////////////////////////////////////////////////////////
	// Completion timing and write strobe
	property p_done; OP_VALID |=> DONE; endproperty
	a_done: assert property (p_done) else $error("no completion after issue");
	property p_idle; !OP_VALID |=> !DONE; endproperty
	a_idle: assert property (p_idle) else $error("completion without issue");
	property p_we; 1'b1 |-> DEST_WE == (DONE && !TRAP) && (DONE || !TRAP); endproperty
	a_we: assert property (p_we) else $error("write strobe or trap misplaced");
	// Trap only from enabled sources or the error source
	property p_trap; DONE |-> TRAP == (CAUSE[BIT_E] || |(CAUSE[4:0] & $past(EXC_ENABLE))); endproperty
	a_trap: assert property (p_trap) else $error("trap disagrees with enables");
	// Sticky flags gather causes and hold otherwise
	property p_sticky; DONE && !$past(FLAG_LOAD) |-> FLAGS == ($past(FLAGS) | CAUSE[4:0]); endproperty
	a_sticky: assert property (p_sticky) else $error("flags not merged with cause");
	property p_hold; !OP_VALID && !FLAG_LOAD |=> $stable(FLAGS) && $stable(CAUSE); endproperty
	a_hold: assert property (p_hold) else $error("status moved while idle");
	// Vector operations
	property p_inner; OP_VALID && OP_KIND == inner_product_op |=> CAUSE[BIT_I] && FLAGS[BIT_I]; endproperty
	a_inner: assert property (p_inner) else $error("inner product without inexact");
	property p_bound;
		OP_VALID && ERR_BOUND_OVF && OP_KIND inside {inner_product_op, matrix_vector_transform_op}
			|=> CAUSE[BIT_O];
	endproperty
	a_bound: assert property (p_bound) else $error("error bound overflow not flagged");
	c_trap: cover property (DONE && TRAP);
	c_inner: cover property (DONE && CAUSE == 6'h01 && FLAGS[BIT_I]);
	c_load: cover property (FLAG_LOAD ##1 !DONE);
endmodule

bind fpu_flag_unit fpu_flag_unit_asserts chk (.CLOCK(CLOCK), .RSTN(RSTN), .EXC_ENABLE(EXC_ENABLE),
	.FLAG_LOAD(FLAG_LOAD), .OP_VALID(OP_VALID), .OP_KIND(OP_KIND), .ERR_BOUND_OVF(ERR_BOUND_OVF),
	.DONE(DONE), .DEST_WE(DEST_WE), .CAUSE(CAUSE), .FLAGS(FLAGS), .TRAP(TRAP));

// ==== verif/issue_model.sv ====
// Issue pipeline model presenting completing operations to the FPU stage
`timescale 1ns/1ps
module issue_model
	import fpu_flag_pkg::*;
(
	input  wire logic   clk,
	output logic        valid,
	output op_kind_t    kind,
	output logic [65:0] raw,
	output logic [3:0]  src,
	output logic [4:0]  vec,
	output logic [73:0] opx
);
	// Idle at time zero
	initial begin
		valid = 1'b0;
		kind = fp_add_op;
		{raw, src, vec, opx} = '0;
	end
	// One-cycle issue; afterwards the operand lines carry inverted junk
	task automatic issue(input op_kind_t k, input logic [65:0] r, input logic [3:0] s,
		input logic [4:0] v, input logic [73:0] x);
		@(posedge clk);
		valid <= 1'b1;
		kind  <= k;
		{raw, src, vec, opx} <= {r, s, v, x};
		@(posedge clk);
		valid <= 1'b0;
		{raw, src, vec, opx} <= ~{r, s, v, x};
		#1;
	endtask
endmodule

// ==== verif/fpu_flag_rounding_behaviour_tb.sv ====
// Self-checking bench for the FPU flag and rounding stage
`timescale 1ns/1ps
module fpu_flag_rounding_behaviour_tb
	import fpu_flag_pkg::*;
;
	logic        clk, rstn, prec, fl, valid, done, we, trap;
	logic [1:0]  mode;
	logic [4:0]  en, fld, flags, vec;
	op_kind_t    kind;
	logic [65:0] raw, r;
	logic [3:0]  src;
	logic [73:0] opx;
	logic [63:0] data;
	logic [5:0]  cause;
	logic [72:0] w;
	int          n_mismatch, samples_checked, i, q;
	int          gaps[4] = '{42, 43, 50, 51};
	////////////////////////////////////////////////////////////////////////////
	issue_model m (.clk(clk), .valid(valid), .kind(kind), .raw(raw), .src(src), .vec(vec), .opx(opx));
	fpu_flag_unit uut (.CLOCK(clk), .RSTN(rstn), .ROUNDING_MODE_FIELD(mode),
		.PRECISION_SELECT_BIT(prec), .EXC_ENABLE(en), .FLAG_LOAD(fl), .FLAG_LOAD_DATA(fld),
		.OP_VALID(valid), .OP_KIND(kind), .RAW_SIGN(raw[65]), .RAW_EXP(raw[64:54]),
		.RAW_FRAC(raw[53:2]), .RAW_GUARD(raw[1]), .RAW_STICKY(raw[0]), .SRC_ERROR(src[3]),
		.SRC_INVALID(src[2]), .SRC_DIVZERO(src[1]), .SRC_OVERFLOW(src[0]),
		.ERR_BOUND_OVF(vec[4]), .INF_OPERAND_COUNT(vec[3:1]), .INF_SAME_SIGN(vec[0]),
		.OPN_EXP(opx[73:63]), .OPM_EXP(opx[62:52]), .SMALL_MANT(opx[51:0]), .DONE(done),
		.DEST_WE(we), .DEST_DATA(data), .CAUSE(cause), .FLAGS(flags), .TRAP(trap));
	////////////////////////////////////////////////////////////////////////////
	// Helpers: packing, comparison, bus steps, verdict
	function automatic logic [72:0] ex(input logic [5:0] c, input logic t, input logic [63:0] d);
		return {c, 1'b1, ~t, t, d};
	endfunction
	function automatic logic [65:0] sr(input logic s, input logic [7:0] e, input logic [23:0] f);
		return {s, 3'h0, e, f, 28'h0, 2'h0};
	endfunction
	task check(input logic [72:0] seen, input logic [72:0] want);
		samples_checked++;
		if (seen !== want) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task cfg(input logic [1:0] md, input logic p, input logic [4:0] e);
		@(posedge clk);
		mode <= md;
		prec <= p;
		en <= e;
	endtask
	task run(input op_kind_t k, input logic [65:0] rv, input logic [3:0] s, input logic [4:0] v,
		input logic [73:0] x, input logic [72:0] wv);
		m.issue(k, rv, s, v, x);
		check({cause, done, we, trap, data}, wv);
	endtask
	task load(input logic [4:0] d);
		@(posedge clk);
		fl <= 1'b1;
		fld <= d;
		@(posedge clk);
		fl <= 1'b0;
		#1;
	endtask
	task print_verdict;
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Clock and watchdog
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#5000;
		n_mismatch++;
		print_verdict;
	end
	// Main sequence
	initial begin
		{rstn, prec, fl, mode, en, fld} = '0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		load(5'h1f);
		check({68'h0, flags}, 73'h1f);
		load(5'h00);
		check({68'h0, flags}, 73'h0);
		// Tiny results rounding up to normal, both signs and precisions, underflow trap armed
		for (i = 0; i < 4; i++) begin
			cfg(2'h0, i[1], 5'h02);
			r = i[1] ? {i[0], 11'h0, 52'hfffffffffffff, 2'h2} : sr(i[0], 8'h0, 24'hffffff);
			w = ex(6'h01, 1'b0, i[1] ? {i[0], 63'h10000000000000} : {32'h0, i[0], 31'h800000});
			run(fp_multiply_op, r, 4'h0, 5'h0, 74'h0, w);
		end
		cfg(2'h1, 1'b0, 5'h00);
		run(fp_multiply_op, sr(0, 8'h0, 24'hffffff), 4'h0, 5'h0, 74'h0, ex(6'h03, 0, 64'h7fffff));
		check({68'h0, flags}, 73'h03);
		cfg(2'h0, 1'b0, 5'h00);
		run(fp_add_op, sr(0, 8'h7f, 24'h0), 4'h0, 5'h0, 74'h0, ex(6'h00, 0, 64'h3f800000));
		check({68'h0, flags}, 73'h03);
		// Overflow: toward zero gives the largest normal, nearest gives infinity
		cfg(2'h1, 1'b0, 5'h00);
		run(fp_multiply_op, sr(0, 8'hff, 24'h0), 4'h0, 5'h0, 74'h0,
			ex(6'h05, 0, 64'h7f7fffff));
		cfg(2'h0, 1'b0, 5'h00);
		run(fp_multiply_op, sr(1, 8'hfe, 24'hffffff), 4'h0, 5'h0, 74'h0,
			ex(6'h05, 0, 64'hff800000));
		run(fp_divide_op, sr(0, 8'h7f, 24'h0), 4'h5, 5'h0, 74'h0,
			ex(6'h15, 0, 64'h3f800000));
		check({68'h0, flags}, 73'h17);
		cfg(2'h0, 1'b0, 5'h08);
		m.issue(fp_divide_op, sr(0, 8'h7f, 24'h0), 4'h2, 5'h0, 74'h0);
		check({64'h0, cause, done, we, trap}, {64'h0, 6'h08, 3'b101});
		cfg(2'h0, 1'b0, 5'h01);
		m.issue(fp_multiply_op, sr(0, 8'h0, 24'hffffff), 4'h0, 5'h0, 74'h0);
		check({64'h0, cause, done, we, trap}, {64'h0, 6'h01, 3'b101});
		// The error source traps with every enable clear
		cfg(2'h0, 1'b0, 5'h00);
		m.issue(fp_add_op, sr(0, 8'h7f, 24'h0), 4'h8, 5'h0, 74'h0);
		check({64'h0, cause, done, we, trap}, {64'h0, 6'h20, 3'b101});
		// Vector operations
		cfg(2'h0, 1'b0, 5'h00);
		run(inner_product_op, sr(0, 8'h7f, 24'h0), 4'h0, 5'h03, 74'h0, ex(6'h01, 0, 64'h3f800000));
		run(matrix_vector_transform_op, 66'h0, 4'h0, 5'h10, 74'h0, ex(6'h05, 0, 64'h0));
		run(inner_product_op, sr(0, 8'h7f, 24'h0), 4'h0, 5'h05, 74'h0, ex(6'h01, 0, 64'hbf800000));
		// Double add/subtract around the missed-inexact exponent gap, both rounding modes
		for (i = 0; i < 8; i++) begin
			cfg(i[3:2] == 2'h0 ? 2'h0 : 2'h1, 1'b1, 5'h00);
			q = (gaps[i % 4] >= 43 && gaps[i % 4] <= 50) ? 1 : 0;
			w = ex(q ? 6'h00 : 6'h01, 1'b0, {60'h3ff000000000000, 3'h0, q[0]});
			run(i[0] ? fp_subtract_op : fp_add_op, {1'b0, 11'h3ff, 52'h0, 2'h2}, 4'h0, 5'h0,
				{11'h400 + 11'(gaps[i % 4]), 11'h400, 52'h1000000}, w);
		end
		print_verdict;
	end
endmodule
